/* File: hdl/rat_pkg.sv */
// Package of constants, tables and types for the redundant autotest sequencer
package rat_pkg;
	localparam int unsigned CLK_MHZ = 200;

	// Register offsets (byte addresses)
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_IVL    = 8'h04;
	localparam logic [7:0] A_INSEL  = 8'h08;
	localparam logic [7:0] A_OUTSEL = 8'h0c;
	localparam logic [7:0] A_NRMEN  = 8'h10;
	localparam logic [7:0] A_STAT   = 8'h14;
	localparam logic [7:0] A_RES    = 8'h20;
	localparam logic [7:0] A_RES_HI = 8'h3c;

	// Field positions and reset values
	localparam int          B_EN     = 0;
	localparam int          B_ID     = 1;
	localparam int          B_W32    = 3;
	localparam logic [15:0] IVL_RST  = 16'h003c;
	localparam logic [31:0] ZERO_RST = 32'h0000_0000;

	// Times in their own units, then cycles
	localparam real         T_PMIN_MS = 1.7;
	localparam real         T_PMAX_MS = 20.0;
	localparam real         T_GMIN_MS = 5.0;
	localparam real         T_GMAX_MS = 15.0;
	localparam real         T_ON1_MS  = 5.0;
	localparam real         T_ON2_MS  = 7.5;
	localparam real         T_IN_MS   = 5.0;
	localparam int unsigned T_MIN_S   = 60;
	localparam int unsigned C_PMIN = int'($ceil(T_PMIN_MS * 1.0e3 * CLK_MHZ));
	localparam int unsigned C_PMAX = int'($floor(T_PMAX_MS * 1.0e3 * CLK_MHZ));
	localparam int unsigned C_GMIN = int'($ceil(T_GMIN_MS * 1.0e3 * CLK_MHZ));
	localparam int unsigned C_GMAX = int'($floor(T_GMAX_MS * 1.0e3 * CLK_MHZ));
	localparam int unsigned C_ON1  = int'($ceil(T_ON1_MS * 1.0e3 * CLK_MHZ));
	localparam int unsigned C_ON2  = int'($ceil(T_ON2_MS * 1.0e3 * CLK_MHZ));
	localparam int unsigned C_IN   = int'($ceil(T_IN_MS * 1.0e3 * CLK_MHZ));
	localparam longint unsigned C_MIN = longint'(T_MIN_S) * 64'd1000000 * longint'(CLK_MHZ);

	localparam logic [2:0] RETRY_MAX = 3'd7;
	localparam logic [1:0] LAST_PASS = 2'd3;
	localparam logic [2:0] LAST_WORD = 3'd6;

	// Input circuit sets and per-cycle rotation
	localparam logic [15:0] M16 [3] = '{16'h2a55, 16'h00aa, 16'h5500};
	localparam logic [31:0] M32 [4] = '{32'h11111111, 32'h02222222, 32'h04444444, 32'h88880888};
	localparam logic [1:0]  SH16 [4] = '{2'd0, 2'd1, 2'd2, 2'd0};
	localparam logic [1:0]  SH32 [4] = '{2'd0, 2'd0, 2'd1, 2'd2};

	// Output block roles per pass: C, B, A
	localparam logic [1:0] ROLE_C [4] = '{2'd2, 2'd3, 2'd0, 2'd1};
	localparam logic [1:0] ROLE_B [4] = '{2'd1, 2'd0, 2'd3, 2'd2};
	localparam logic [1:0] ROLE_A [4] = '{2'd0, 2'd1, 2'd2, 2'd3};

	typedef enum logic [3:0] {
		ST_IDLE, ST_IN_RUN, ST_IN_CHK, ST_ANN, ST_SNAP, ST_COND, ST_OVR_C, ST_PUL_B,
		ST_OVR_B, ST_PUL_A, ST_RST, ST_CAN_C, ST_CAN_B, ST_REPORT, ST_DONE
	} rat_st_e;

	typedef struct packed {
		logic [1:0]  pblk;
		logic [15:0] pinv;
		logic [1:0]  cblk;
		logic [15:0] ovr_on;
		logic [1:0]  bblk;
		logic [15:0] ovr_off;
		logic        blk_reset;
	} rat_out_ctl_s;

	typedef struct packed {
		logic [2:0]       feed_off;
		logic [2:0][31:0] chan_on;
	} rat_in_ctl_s;
endpackage : rat_pkg

/* File: hdl/rat_pulse.sv */
// Pulse tester for one output block of the group
`timescale 1ns/10ps
module rat_pulse #(
	parameter int unsigned PMIN = rat_pkg::C_PMIN,
	parameter int unsigned PMAX = rat_pkg::C_PMAX,
	parameter int unsigned GMIN = rat_pkg::C_GMIN,
	parameter int unsigned GMAX = rat_pkg::C_GMAX,
	parameter int unsigned ON1  = rat_pkg::C_ON1,
	parameter int unsigned ON2  = rat_pkg::C_ON2
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        start,
	input  wire logic [15:0] sel,
	input  wire logic [15:0] cmd_snap,
	input  wire logic [15:0] cmd_live,
	input  wire logic [15:0] fb,
	output logic      [15:0] inv_q,
	output logic             done_q,
	output logic      [15:0] fail_q,
	output logic             void_q
);
	import rat_pkg::*;

	logic        busy_q;
	logic        gap_q;
	logic [2:0]  att_q;
	logic [31:0] cnt_q;
	logic [15:0] poff_q;
	logic [15:0] pon_q;
	logic [31:0] t_off;
	logic [31:0] t_on;
	logic [31:0] t_win;
	logic [31:0] t_gap;
	logic        on_act;

	// Longer pulse and gap on every retry
	assign t_off  = 32'(PMIN + (32'(att_q) * (PMAX - PMIN)) / 7);
	assign t_gap  = 32'(GMIN + (32'(att_q) * (GMAX - GMIN)) / 7);
	assign t_on   = (att_q == 3'd0) ? 32'(ON1) : 32'(ON2);
	assign on_act = (att_q < 3'd2) && (pon_q != 16'h0000);
	assign t_win  = (on_act && t_on > t_off) ? t_on : t_off;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			gap_q  <= 1'b0;
			att_q  <= 3'd0;
			cnt_q  <= 32'h0;
			poff_q <= 16'h0000;
			pon_q  <= 16'h0000;
			inv_q  <= 16'h0000;
			done_q <= 1'b0;
			fail_q <= 16'h0000;
			void_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				busy_q <= 1'b1;
				gap_q  <= 1'b0;
				att_q  <= 3'd0;
				cnt_q  <= 32'h0;
				poff_q <= sel & ~cmd_snap;
				pon_q  <= sel & cmd_snap;
				void_q <= 1'b0;
			end else if (busy_q && ((cmd_live & sel) != (cmd_snap & sel))) begin
				busy_q <= 1'b0;
				inv_q  <= 16'h0000;
				fail_q <= 16'h0000;
				void_q <= 1'b1;
				done_q <= 1'b1;
			end else if (busy_q && !gap_q) begin
				// Only still-failing points are pulsed
				inv_q <= (poff_q & {16{cnt_q < t_off}}) | (pon_q & {16{on_act && cnt_q < t_on}});
				if (cnt_q == t_off - 32'd1) begin
					poff_q <= poff_q & ~(fb ^ cmd_snap);
				end
				if (on_act && cnt_q == t_on - 32'd1) begin
					pon_q <= pon_q & ~(fb ^ cmd_snap);
				end
				if (cnt_q >= t_win - 32'd1) begin
					gap_q <= 1'b1;
					cnt_q <= 32'h0;
				end else begin
					cnt_q <= cnt_q + 32'd1;
				end
			end else if (busy_q) begin
				inv_q <= 16'h0000;
				if (cnt_q < t_gap - 32'd1) begin
					cnt_q <= cnt_q + 32'd1;
				end else if (att_q == RETRY_MAX || (poff_q == 16'h0000 && (pon_q == 16'h0000
						|| att_q != 3'd0))) begin
					busy_q <= 1'b0;
					fail_q <= poff_q | pon_q;
					done_q <= 1'b1;
				end else begin
					att_q <= att_q + 3'd1;
					gap_q <= 1'b0;
					cnt_q <= 32'h0;
				end
			end
		end
	end
endmodule : rat_pulse

/* File: hdl/rat_res_mem.sv */
// Result store and register read-data register
`timescale 1ns/10ps
module rat_res_mem (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        we,
	input  wire logic [2:0]  waddr,
	input  wire logic [31:0] wdata,
	input  wire logic        rd,
	input  wire logic        use_mem,
	input  wire logic [2:0]  raddr,
	input  wire logic [31:0] alt_data,
	output logic      [31:0] rdata_q
);
	import rat_pkg::*;

	logic [31:0] mem [8];

	// Cleared at reset so result words read zero before the first turn
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem <= '{default: ZERO_RST};
		end else if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= ZERO_RST;
		end else if (rd) begin
			rdata_q <= use_mem ? mem[raddr] : alt_data;
		end else begin
			rdata_q <= ZERO_RST;
		end
	end
endmodule : rat_res_mem

/* File: hdl/rat_seq.sv */
// Redundant I/O autotest sequencer top
// What this block does
// - Start pass every configured 0-65535 minute interval
// - Master role rotates among redundant PLCs
// - Rotation skips unavailable PLCs, testing continues
// - Only discrete points selected for autotest
// - One start command, block runs test alone
// - Per-circuit input autotest selection
// - Power feed pulsed off, selected channels on
// - Wrong sensed state raises input fault
// - Hold last valid inputs during test
// - Sixteen-circuit masks rotate over blocks A-C
// - Thirty-two-circuit four sets rotate likewise
// - Master announces group before testing it
// - Read diagnostics, suppress group faults meanwhile
// - Capture commanded and force states first
// - Seven-step override, pulse, reset, cancel pass
// - Repeat pass with roles D/A/B, A/D/C, B/C/D
// - Send results, log faults, next group
// - Pulse only if online, unforced, agreeing
// - Off points off-on-off, seven longer retries
// - On points on-off-on, one longer retry
// - Output change mid-test voids result
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module rat_seq #(
	parameter longint unsigned MIN_CYC = rat_pkg::C_MIN,
	parameter int unsigned     IN_CYC  = rat_pkg::C_IN,
	parameter int unsigned     PMIN    = rat_pkg::C_PMIN,
	parameter int unsigned     PMAX    = rat_pkg::C_PMAX,
	parameter int unsigned     GMIN    = rat_pkg::C_GMIN,
	parameter int unsigned     GMAX    = rat_pkg::C_GMAX,
	parameter int unsigned     ON1     = rat_pkg::C_ON1,
	parameter int unsigned     ON2     = rat_pkg::C_ON2
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [7:0]            reg_addr,
	input  wire logic [31:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [31:0]           reg_rdata,
	input  wire logic [2:0]            plc_up,
	input  wire logic                  peer_ann,
	input  wire logic                  peer_done_tgl,
	input  wire logic [2:0][31:0]      in_raw,
	output logic      [2:0][31:0]      in_held_q,
	output rat_pkg::rat_in_ctl_s       in_ctl_q,
	input  wire logic [3:0][15:0]      out_fb,
	input  wire logic [15:0]           out_cmd,
	input  wire logic [15:0]           out_forced,
	input  wire logic [15:0]           out_hwf,
	input  wire logic [3:0]            blk_online,
	input  wire logic                  grp_ovr,
	output rat_pkg::rat_out_ctl_s      out_ctl_q,
	output logic                       ann_q,
	output logic                       diag_rd_q,
	output logic                       suppress_q,
	output logic                       rpt_tgl_q,
	output logic                       master_q
);
	import rat_pkg::*;

	localparam int SW = 202;

	logic [SW-1:0]     sa_q;
	logic [SW-1:0]     sb_q;
	logic [2:0]        up_s;
	logic              pann_s;
	logic              pdone_s;
	logic [2:0][31:0]  in_s;
	logic [3:0][15:0]  fb_s;
	logic [15:0]       frc_s;
	logic [15:0]       hwf_s;
	logic [3:0]        onl_s;
	logic              ovr_s;
	logic              pdone_q;
	logic              pann_q;
	logic              en_q;
	logic [1:0]        id_q;
	logic              w32_q;
	logic [15:0]       ivl_q;
	logic [31:0]       insel_q;
	logic [15:0]       outsel_q;
	logic [15:0]       nrm_q;
	rat_st_e           st_q;
	logic [35:0]       pre_q;
	logic [15:0]       min_q;
	logic [1:0]        mst_q;
	logic [1:0]        cyc_q;
	logic [1:0]        pass_q;
	logic [31:0]       cnt_q;
	logic [2:0]        widx_q;
	logic [15:0]       snap_q;
	logic [15:0]       fsnap_q;
	logic [3:0][15:0]  oflt_q;
	logic [2:0][31:0]  iflt_q;
	logic [2:0][31:0]  imask;
	logic              go;
	logic              turn_end;
	logic              cond_ok;
	logic              pu_start;
	logic [15:0]       pu_inv;
	logic              pu_done;
	logic [15:0]       pu_fail;
	logic              pu_void;
	logic [31:0]       alt_data;
	logic [31:0]       mem_wdata;

	// Every pin-side input except out_cmd passes two flops first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sa_q <= '0;
			sb_q <= '0;
		end else begin
			sa_q <= {plc_up, peer_ann, peer_done_tgl, in_raw, out_fb, out_forced, out_hwf,
				blk_online, grp_ovr};
			sb_q <= sa_q;
		end
	end
	assign {up_s, pann_s, pdone_s, in_s, fb_s, frc_s, hwf_s, onl_s, ovr_s} = sb_q;

	// Register writes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q     <= 1'b0;
			id_q     <= 2'd0;
			w32_q    <= 1'b0;
			ivl_q    <= IVL_RST;
			insel_q  <= ZERO_RST;
			outsel_q <= 16'h0000;
			nrm_q    <= 16'h0000;
		end else if (reg_wr) begin
			unique case (reg_addr)
				A_CTRL: begin
					en_q  <= reg_wdata[B_EN];
					id_q  <= reg_wdata[B_ID +: 2];
					w32_q <= reg_wdata[B_W32];
				end
				A_IVL:    ivl_q    <= reg_wdata[15:0];
				A_INSEL:  insel_q  <= reg_wdata;
				A_OUTSEL: outsel_q <= reg_wdata[15:0];
				A_NRMEN:  nrm_q    <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		alt_data = ZERO_RST;
		unique case (reg_addr)
			A_CTRL:   alt_data = {28'h0, w32_q, id_q, en_q};
			A_IVL:    alt_data = {16'h0, ivl_q};
			A_INSEL:  alt_data = insel_q;
			A_OUTSEL: alt_data = {16'h0, outsel_q};
			A_NRMEN:  alt_data = {16'h0, nrm_q};
			A_STAT:   alt_data = {16'h0, 1'b0, master_q, mst_q, cyc_q, pass_q, 4'(st_q), 1'b0, up_s};
			default:  alt_data = ZERO_RST;
		endcase
	end

	rat_res_mem u_mem (
		.clk      (clk),
		.rst_n    (rst_n),
		.we       (st_q == ST_REPORT),
		.waddr    (widx_q),
		.wdata    (mem_wdata),
		.rd       (reg_rd),
		.use_mem  (reg_addr >= A_RES && reg_addr <= A_RES_HI),
		.raddr    (reg_addr[4:2]),
		.alt_data (alt_data),
		.rdata_q  (reg_rdata)
	);
	// Words 0..3 output blocks, 4..6 input blocks
	assign mem_wdata = widx_q[2] ? iflt_q[widx_q[1:0]] : {16'h0, oflt_q[widx_q[1:0]]};

	// Minute timer; restarted in each PLC at every turn end so the next master starts on time
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_q <= 36'h0;
			min_q <= 16'h0000;
		end else if (turn_end || st_q != ST_IDLE) begin
			pre_q <= 36'h0;
			min_q <= 16'h0000;
		end else if (pre_q == 36'(MIN_CYC - 64'd1)) begin
			pre_q <= 36'h0;
			if (min_q != 16'hffff) begin
				min_q <= min_q + 16'h0001;
			end
		end else begin
			pre_q <= pre_q + 36'h1;
		end
	end

	// Master rotation over the PLCs that are up
	assign turn_end = (pdone_s != pdone_q) || (st_q == ST_DONE);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pdone_q  <= 1'b0;
			pann_q   <= 1'b0;
			mst_q    <= 2'd0;
			master_q <= 1'b0;
		end else begin
			pdone_q <= pdone_s;
			pann_q  <= pann_s;
			if (turn_end || !up_s[mst_q]) begin
				if (up_s[(mst_q == 2'd2) ? 2'd0 : mst_q + 2'd1]) begin
					mst_q <= (mst_q == 2'd2) ? 2'd0 : mst_q + 2'd1;
				end else if (up_s[(mst_q == 2'd0) ? 2'd2 : mst_q - 2'd1]) begin
					mst_q <= (mst_q == 2'd0) ? 2'd2 : mst_q - 2'd1;
				end
			end
			master_q <= en_q && (mst_q == id_q);
		end
	end
	// Master flag lags the rotation by a cycle; without the id test a turn would restart
	assign go = master_q && (mst_q == id_q) && st_q == ST_IDLE && min_q >= ivl_q;

	// Input set per block for the present cycle
	for (genvar b = 0; b < 3; b++) begin : g_imask
		logic [1:0] sx;
		assign sx = 2'((b + int'(w32_q ? SH32[cyc_q] : SH16[cyc_q])) % 3);
		// Circuit 16 feeds sensor power and never joins a set
		assign imask[b] = insel_q & 32'hffff_7fff & (w32_q ?
			(M32[sx] | ((sx == 2'd2) ? M32[3] : 32'h0)) : {16'h0, M16[sx]});
	end

	assign cond_ok = (&onl_s) && !ovr_s && ((frc_s | hwf_s) & outsel_q) == 16'h0000 &&
		(((fb_s[0] ^ fb_s[1]) | (fb_s[0] ^ fb_s[2]) | (fb_s[0] ^ fb_s[3])) & outsel_q)
		== 16'h0000;
	assign pu_start = (st_q == ST_OVR_C) || (st_q == ST_OVR_B);

	rat_pulse #(
		.PMIN (PMIN),
		.PMAX (PMAX),
		.GMIN (GMIN),
		.GMAX (GMAX),
		.ON1  (ON1),
		.ON2  (ON2)
	) u_pulse (
		.clk      (clk),
		.rst_n    (rst_n),
		.start    (pu_start),
		.sel      (outsel_q),
		.cmd_snap (snap_q),
		.cmd_live (out_cmd),
		.fb       (fb_s[out_ctl_q.pblk]),
		.inv_q    (pu_inv),
		.done_q   (pu_done),
		.fail_q   (pu_fail),
		.void_q   (pu_void)
	);

	// Sequence state machine
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q   <= ST_IDLE;
			cnt_q  <= 32'h0;
			pass_q <= 2'd0;
			widx_q <= 3'd0;
		end else begin
			unique case (st_q)
				ST_IDLE: if (go) begin
					st_q  <= ST_IN_RUN;
					cnt_q <= 32'h0;
				end
				ST_IN_RUN: begin
					cnt_q <= cnt_q + 32'd1;
					if (cnt_q == IN_CYC - 32'd1) begin
						st_q <= ST_IN_CHK;
					end
				end
				ST_IN_CHK: st_q <= ST_ANN;
				ST_ANN:    st_q <= ST_SNAP;
				ST_SNAP: begin
					st_q   <= ST_COND;
					pass_q <= 2'd0;
				end
				ST_COND:  st_q <= cond_ok ? ST_OVR_C : ST_REPORT;
				ST_OVR_C: st_q <= ST_PUL_B;
				ST_PUL_B: if (pu_done) st_q <= ST_OVR_B;
				ST_OVR_B: st_q <= ST_PUL_A;
				ST_PUL_A: if (pu_done) st_q <= ST_RST;
				ST_RST:   st_q <= ST_CAN_C;
				ST_CAN_C: st_q <= ST_CAN_B;
				ST_CAN_B: begin
					if (pass_q == LAST_PASS) begin
						st_q   <= ST_REPORT;
						widx_q <= 3'd0;
					end else begin
						pass_q <= pass_q + 2'd1;
						st_q   <= ST_COND;
					end
				end
				ST_REPORT: begin
					widx_q <= widx_q + 3'd1;
					if (widx_q == LAST_WORD) begin
						st_q <= ST_DONE;
					end
				end
				ST_DONE: st_q <= ST_IDLE;
			endcase
		end
	end

	// Input self-test drive, checking and held data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_ctl_q  <= '0;
			in_held_q <= '0;
			iflt_q    <= '0;
			cyc_q     <= 2'd0;
		end else begin
			if (st_q == ST_IN_RUN) begin
				in_ctl_q.feed_off <= 3'b111;
				in_ctl_q.chan_on  <= imask;
			end else begin
				in_ctl_q <= '0;
			end
			if (st_q == ST_IN_RUN && cnt_q == IN_CYC - 32'd1) begin
				for (int b = 0; b < 3; b++) begin
					iflt_q[b] <= iflt_q[b] | (insel_q & 32'hffff_7fff & (imask[b] ^ in_s[b]));
				end
			end
			if (st_q == ST_IDLE) begin
				in_held_q <= in_s;
			end
			if (st_q == ST_IN_CHK) begin
				cyc_q <= cyc_q + 2'd1;
			end
			if (st_q == ST_DONE) begin
				iflt_q <= '0;
			end
		end
	end

	// Output group drive, overrides and result gathering
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_ctl_q <= '0;
			snap_q    <= 16'h0000;
			fsnap_q   <= 16'h0000;
			oflt_q    <= '0;
		end else begin
			out_ctl_q.pinv      <= pu_inv;
			out_ctl_q.blk_reset <= (st_q == ST_RST);
			if (st_q == ST_SNAP) begin
				snap_q  <= out_cmd;
				fsnap_q <= frc_s;
			end
			unique case (st_q)
				ST_OVR_C: begin
					out_ctl_q.cblk   <= ROLE_C[pass_q];
					out_ctl_q.ovr_on <= outsel_q & ~nrm_q;
					out_ctl_q.pblk   <= ROLE_B[pass_q];
				end
				ST_PUL_B: if (pu_done && !pu_void) begin
					oflt_q[ROLE_B[pass_q]] <= oflt_q[ROLE_B[pass_q]] | pu_fail;
				end
				ST_OVR_B: begin
					out_ctl_q.bblk    <= ROLE_B[pass_q];
					out_ctl_q.ovr_off <= oflt_q[ROLE_B[pass_q]] & nrm_q & outsel_q;
					out_ctl_q.pblk    <= ROLE_A[pass_q];
				end
				ST_PUL_A: if (pu_done && !pu_void) begin
					oflt_q[ROLE_A[pass_q]] <= oflt_q[ROLE_A[pass_q]] | pu_fail;
				end
				ST_CAN_C: out_ctl_q.ovr_on <= 16'h0000;
				// Tripped outputs stay forced off until the next ST_OVR_B step rewrites ovr_off
				ST_CAN_B: out_ctl_q.ovr_off <= out_ctl_q.ovr_off & hwf_s;
				ST_DONE:  oflt_q <= '0;
				default: ;
			endcase
		end
	end

	// Peer messages and fault suppression
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ann_q      <= 1'b0;
			diag_rd_q  <= 1'b0;
			suppress_q <= 1'b0;
			rpt_tgl_q  <= 1'b0;
		end else begin
			if (st_q == ST_ANN) begin
				ann_q <= 1'b1;
			end else if (st_q == ST_DONE) begin
				ann_q <= 1'b0;
			end
			diag_rd_q  <= (st_q == ST_ANN) || (pann_s && !pann_q);
			suppress_q <= ann_q || pann_s;
			if (st_q == ST_DONE) begin
				rpt_tgl_q <= ~rpt_tgl_q;
			end
		end
	end
endmodule : rat_seq

/* File: testbench/rat_far_model.sv */
// Far-side model of the input and output blocks
`timescale 1ns/10ps
module rat_far_model (
	input wire logic [2:0][31:0] live,
	input wire logic [31:0]      in_bad,
	input wire logic [15:0]      dead_b,
	input wire logic [15:0]      out_cmd,
	input rat_pkg::rat_in_ctl_s  in_ctl,
	input rat_pkg::rat_out_ctl_s out_ctl,
	output logic [2:0][31:0]     in_raw,
	output logic [3:0][15:0]     out_fb
);
	import rat_pkg::*;
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			// Feed off: only channels driven on read high
			in_raw[i] = in_ctl.feed_off[i] ? in_ctl.chan_on[i] : live[i];
		end
		// Broken channel reads inverted, only under
		in_raw[0] = in_raw[0] ^ (in_ctl.feed_off[0] ? in_bad : 32'h0);
		for (int k = 0; k < 4; k++) begin
			// Blocks agree; pulsed block inverts, dead switch on B ignores it
			out_fb[k] = out_cmd ^ (out_ctl.pblk == 2'(k) ? out_ctl.pinv : 16'h0);
			out_fb[k] = k == 1 ? (out_fb[k] & ~dead_b) | (out_cmd & dead_b) : out_fb[k];
		end
	end
endmodule : rat_far_model

/* File: testbench/rat_seq_props.sv */
// Port checker of the autotest sequencer
`timescale 1ns/10ps
module rat_seq_chk (
	input wire logic             clk,
	input wire logic             rst_n,
	input wire logic [2:0][31:0] in_held_q,
	input rat_pkg::rat_in_ctl_s  in_ctl_q,
	input rat_pkg::rat_out_ctl_s out_ctl_q,
	input wire logic [3:0]       blk_online,
	input wire logic             grp_ovr,
	input wire logic [15:0]      out_forced,
	input wire logic             ann_q,
	input wire logic             diag_rd_q,
	input wire logic             suppress_q,
	input wire logic             master_q
);
	import rat_pkg::*;
	wire [2:0][31:0] chan = in_ctl_q.chan_on;
	wire             feed = |in_ctl_q.feed_off;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_held;
		feed && $past(feed) |-> $stable(in_held_q);
	endproperty
	a_held: assert property (p_held) else $error("held inputs moved");
	property p_excl;
		((chan[0] & chan[1]) | (chan[0] & chan[2]) | (chan[1] & chan[2])
			| ((chan[0] | chan[1] | chan[2]) & 32'h8000)) == 32'h0;
	endproperty
	a_excl: assert property (p_excl) else $error("channel on twice");
	property p_feed;
		({|chan[2], |chan[1], |chan[0]} & ~in_ctl_q.feed_off) == 3'b000;
	endproperty
	a_feed: assert property (p_feed) else $error("channel on with feed on");
	property p_ann;
		diag_rd_q |-> ann_q || suppress_q;
	endproperty
	a_ann: assert property (p_ann) else $error("diag read unannounced");
	property p_diag;
		diag_rd_q |=> !diag_rd_q;
	endproperty
	a_diag: assert property (p_diag) else $error("diag read too long");
	property p_rst;
		out_ctl_q.blk_reset |-> ann_q ##1 !out_ctl_q.blk_reset;
	endproperty
	a_rst: assert property (p_rst) else $error("bad block reset");
	property p_cond;
		|out_ctl_q.pinv |-> &blk_online && !grp_ovr && out_forced == 16'h0;
	endproperty
	a_cond: assert property (p_cond) else $error("pulse while unfit");
	property p_mst;
		$rose(ann_q) |-> master_q;
	endproperty
	a_mst: assert property (p_mst) else $error("turn without master");
endmodule : rat_seq_chk
bind rat_seq rat_seq_chk u_chk (.clk, .rst_n, .in_held_q, .in_ctl_q, .out_ctl_q, .blk_online,
	.grp_ovr, .out_forced, .ann_q, .diag_rd_q, .suppress_q, .master_q);

/* File: testbench/tb_top.sv */
// Self-checking bench of the autotest sequencer
`timescale 1ns/10ps
module tb_top;
	import rat_pkg::*;
	logic             clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic             peer_ann = 1'b0, peer_done_tgl = 1'b0, grp_ovr = 1'b0;
	logic             ann_q, diag_rd_q, suppress_q, rpt_tgl_q, master_q;
	logic [7:0]       reg_addr = 8'h00;
	logic [31:0]      reg_wdata = 32'h0, in_bad = 32'h0, reg_rdata, insel, d;
	logic [2:0]       plc_up = 3'b111;
	logic [3:0]       blk_online = 4'hf;
	logic [15:0]      out_cmd = 16'h0, out_forced = 16'h0, out_hwf = 16'h0, dead_b = 16'h0;
	logic [15:0]      outsel;
	logic [2:0][31:0] live = '0, in_raw, in_held_q;
	logic [3:0][15:0] out_fb;
	rat_in_ctl_s      in_ctl_q;
	rat_out_ctl_s     out_ctl_q;
	logic [31:0]      exp_w [7];
	int               fail_count = 0, tests_run = 0, cyc = 0, seed = 32'h49e8, n;

	rat_seq #(.MIN_CYC(100), .IN_CYC(20), .PMIN(10), .PMAX(80), .GMIN(10), .GMAX(30),
		.ON1(10), .ON2(15)) dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .plc_up, .peer_ann, .peer_done_tgl, .in_raw, .in_held_q, .in_ctl_q,
		.out_fb, .out_cmd, .out_forced, .out_hwf, .blk_online, .grp_ovr, .out_ctl_q,
		.ann_q, .diag_rd_q, .suppress_q, .rpt_tgl_q, .master_q);
	rat_far_model far (.live, .in_bad, .dead_b, .out_cmd, .in_ctl(in_ctl_q),
		.out_ctl(out_ctl_q), .in_raw, .out_fb);

	always #2.5 clk = ~clk;
	// Ceiling well above seven turns of worst-case retries
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 95000) begin
			fail_count++;
			end_sim();
		end
	end

	function automatic logic [31:0] one_hot(input int b);
		return 32'h1 << b;
	endfunction : one_hot

	task automatic end_sim();
		$display("tests %0d wrong %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
		@(posedge clk);
	endtask : rd

	// Config while a peer is master, then hand the turn back
	task automatic give(input logic [31:0] ctrl, input int tgl, input logic [2:0] up);
		wr(A_INSEL, insel);
		wr(A_OUTSEL, {16'h0, outsel});
		wr(A_CTRL, ctrl);
		repeat (tgl) begin
			peer_done_tgl <= ~peer_done_tgl;
			repeat (4) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		chk(master_q, 1'b1);
		plc_up <= up;
	endtask : give

	task automatic fin(input int t);
		logic was;
		int   k;
		was = rpt_tgl_q;
		k = 0;
		while (rpt_tgl_q === was && k < 20000) begin
			@(posedge clk);
			k++;
		end
		chk(k < 20000, 1'b1);
		repeat (4) @(posedge clk);
		chk(master_q, 1'b0);
		for (int i = 0; i < 7; i++) begin
			rd(A_RES + 8'(4 * i), d);
			chk(d, exp_w[i]);
		end
		$display("test %0d done", t);
	endtask : fin

	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(A_IVL, d);
		chk(d, 32'h3c);
		rd(8'h18, d);
		chk(d, 32'h0);
		rd(A_STAT, d);
		chk(d, 32'h7);
		wr(A_RES, 32'hffff_ffff);
		rd(A_RES, d);
		chk(d, 32'h0);
		insel = $random(seed);
		wr(A_INSEL, insel);
		rd(A_INSEL, d);
		chk(d, insel);
		wr(A_IVL, 32'h0);
		wr(A_NRMEN, $random(seed));
		out_cmd <= $random(seed);
		live <= {$random(seed), $random(seed), $random(seed)};
		outsel = $random(seed);
		n = {$random(seed)} % 15;
		// Faulty selected channel on block A
		in_bad <= one_hot(n);
		insel = insel | one_hot(n);
		exp_w = '{default: 32'h0};
		exp_w[4] = one_hot(n);
		give(32'h1, 0, 3'b111);
		fin(1);
		peer_ann <= 1'b1;
		repeat (4) @(posedge clk);
		chk(suppress_q, 1'b1);
		peer_ann <= 1'b0;
		in_bad <= 32'h0;
		exp_w[4] = 32'h0;
		// Thirty-two circuit blocks; one PLC drops mid-turn
		give(32'h9, 2, 3'b101);
		fin(2);
		n = {$random(seed)} % 16;
		dead_b <= 16'(one_hot(n));
		outsel = outsel | 16'(one_hot(n));
		wr(A_NRMEN, 32'h0);
		// Each of forcing, hardware fault, an offline block and group override alone must block all pulsing
		for (int v = 0; v < 4; v++) begin
			out_forced <= (v == 0) ? 16'(one_hot(n)) : 16'h0;
			out_hwf    <= (v == 1) ? 16'(one_hot(n)) : 16'h0;
			blk_online <= (v == 2) ? ~4'(one_hot(n % 4)) : 4'hf;
			grp_ovr    <= (v == 3);
			give(32'h1, 1, 3'b101);
			fin(3);
		end
		out_forced <= 16'h0;
		out_hwf    <= 16'h0;
		blk_online <= 4'hf;
		grp_ovr    <= 1'b0;
		exp_w[1] = one_hot(n);
		wr(A_IVL, 32'h2);
		give(32'h1, 1, 3'b101);
		chk(|in_ctl_q.feed_off | ann_q, 1'b0);
		fin(4);
		end_sim();
	end
endmodule : tb_top
